/* core/spi_eeprom_dev.sv */
// serial eeprom device end: command decode, status, write cycle
//
// The address map and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module spi_eeprom_dev #(
  parameter int WRITE_CYCLE_CYCLES = spi_eeprom_pkg::WRITE_CYCLE_CYCLES
) (
  // clock and reset
  input logic core_clk,
  input logic rst,
  // serial link
  spi_link_if.dev link,
  // memory side
  output logic [15:0] mem_addr,
  input logic [7:0] mem_rdata,
  output logic [7:0] mem_wdata,
  output logic mem_wr,
  // device state
  output logic write_start,
  output logic write_busy,
  output logic standby,
  output logic [7:0] status
);

  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADDR = 3'b001,
    ST_WDATA = 3'b010,
    ST_RDATA = 3'b011,
    ST_SR_WR = 3'b100,
    ST_SR_RD = 3'b101,
    ST_DONE = 3'b110,
    ST_IGNORE = 3'b111
  } dev_state_e;

  logic [4:0] meta_reg;
  logic [4:0] sync_reg;
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic wp_n_s;
  logic hold_n_s;
  logic sck_d_reg;
  logic cs_d_reg;
  logic active;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  dev_state_e state_reg;
  logic [4:0] bit_cnt_reg;
  logic [7:0] in_sh_reg;
  logic [7:0] in_byte;
  logic [7:0] cmd_reg;
  logic [7:0] sr_data_reg;
  logic got_reg;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg;
  logic mem_wr_reg;
  logic addr_shift;
  logic rd_step;
  logic wel_reg;
  logic busy_reg;
  logic pen_reg;
  logic bp_hi_reg;
  logic bp_lo_reg;
  logic start_reg;
  logic [17:0] wc_cnt_reg;
  logic prot;
  logic wr_ok;
  logic sr_ok;
  logic [7:0] status_byte;
  logic [7:0] src_byte;
  logic [7:0] out_sh_reg;
  logic [2:0] out_cnt_reg;
  logic so_reg;
  logic out_state;

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= spi_eeprom_pkg::LINK_IDLE;
      sync_reg <= spi_eeprom_pkg::LINK_IDLE;
    end
    else
    begin
      meta_reg <= {link.hold_n, link.wp_n, link.si, link.sck, link.cs_n};
      sync_reg <= meta_reg;
    end
  end

  assign cs_n_s = sync_reg[0];
  assign sck_s = sync_reg[1];
  assign si_s = sync_reg[2];
  assign wp_n_s = sync_reg[3];
  assign hold_n_s = sync_reg[4];

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sck_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
    end
    else
    begin
      sck_d_reg <= sck_s;
      cs_d_reg <= cs_n_s;
    end
  end

  // edges count only while selected and not paused
  assign active = ~cs_n_s & hold_n_s;
  assign sck_rise = active & sck_s & ~sck_d_reg;
  assign sck_fall = active & ~sck_s & sck_d_reg;
  assign cs_rise = cs_n_s & ~cs_d_reg;
  assign in_byte = {in_sh_reg[6:0], si_s};

  // ---------------------------------------------------------------
  // instruction decode
  // ---------------------------------------------------------------
  function automatic dev_state_e decode(
    input logic [7:0] op,
    input logic busy
  );
    dev_state_e st;
    st = ST_IGNORE;
    case (op)
      spi_eeprom_pkg::SET_WRITE_LATCH_CMD: st = ST_DONE;
      spi_eeprom_pkg::CLEAR_WRITE_LATCH_CMD: st = ST_DONE;
      spi_eeprom_pkg::READ_STATUS_CMD: st = ST_SR_RD;
      spi_eeprom_pkg::WRITE_STATUS_CMD: st = ST_SR_WR;
      spi_eeprom_pkg::READ_DATA_CMD: st = ST_ADDR;
      spi_eeprom_pkg::WRITE_DATA_CMD: st = ST_ADDR;
      default: st = ST_IGNORE;
    endcase
    if (busy && op != spi_eeprom_pkg::READ_STATUS_CMD)
    begin
      st = ST_IGNORE;
    end
    return st;
  endfunction: decode

  // ---------------------------------------------------------------
  // transfer state machine
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= ST_CMD;
      bit_cnt_reg <= 5'h00;
      in_sh_reg <= 8'h00;
      cmd_reg <= 8'h00;
      sr_data_reg <= 8'h00;
      got_reg <= 1'b0;
      wdata_reg <= 8'h00;
      mem_wr_reg <= 1'b0;
    end
    else
    begin
      mem_wr_reg <= 1'b0;
      if (cs_n_s)
      begin
        state_reg <= ST_CMD;
        bit_cnt_reg <= 5'h00;
        got_reg <= 1'b0;
      end
      else if (sck_rise)
      begin
        in_sh_reg <= in_byte;
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        unique case (state_reg)
          ST_CMD:
          begin
            if (bit_cnt_reg == 5'h07)
            begin
              bit_cnt_reg <= 5'h00;
              cmd_reg <= in_byte;
              state_reg <= decode(in_byte, busy_reg);
            end
          end
          ST_ADDR:
          begin
            if (bit_cnt_reg == 5'h0f)
            begin
              bit_cnt_reg <= 5'h00;
              if (cmd_reg == spi_eeprom_pkg::READ_DATA_CMD)
              begin
                state_reg <= ST_RDATA;
              end
              else
              begin
                state_reg <= ST_WDATA;
              end
            end
          end
          ST_WDATA:
          begin
            if (bit_cnt_reg == 5'h07)
            begin
              bit_cnt_reg <= 5'h00;
              wdata_reg <= in_byte;
              mem_wr_reg <= 1'b1;
              got_reg <= 1'b1;
            end
          end
          ST_SR_WR:
          begin
            if (bit_cnt_reg == 5'h07)
            begin
              sr_data_reg <= in_byte;
              got_reg <= 1'b1;
              state_reg <= ST_DONE;
            end
          end
          ST_RDATA, ST_SR_RD, ST_DONE, ST_IGNORE:
          begin
            bit_cnt_reg <= 5'h00;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // address pointer
  // ---------------------------------------------------------------
  assign addr_shift = sck_rise & (state_reg == ST_ADDR);
  assign rd_step = sck_fall & (state_reg == ST_RDATA) &
    (out_cnt_reg == 3'h7);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      addr_reg <= 16'h0000;
    end
    else if (addr_shift)
    begin
      addr_reg <= {addr_reg[14:0], si_s};
    end
    else if (mem_wr_reg || rd_step)
    begin
      addr_reg <= addr_reg + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // status, write latch and self-timed write cycle
  // ---------------------------------------------------------------
  assign prot = ~wp_n_s & pen_reg;
  assign wr_ok = (state_reg == ST_WDATA) & got_reg & wel_reg;
  assign sr_ok = (state_reg == ST_DONE) & got_reg & wel_reg & ~prot &
    (cmd_reg == spi_eeprom_pkg::WRITE_STATUS_CMD);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wel_reg <= spi_eeprom_pkg::WRITE_LATCH_RESET;
      busy_reg <= 1'b0;
      pen_reg <= spi_eeprom_pkg::PROTECT_PIN_ENABLE_RESET;
      bp_hi_reg <= spi_eeprom_pkg::BLOCK_PROTECT_RESET;
      bp_lo_reg <= spi_eeprom_pkg::BLOCK_PROTECT_RESET;
      start_reg <= 1'b0;
      wc_cnt_reg <= 18'h00000;
    end
    else
    begin
      start_reg <= 1'b0;
      if (busy_reg)
      begin
        wc_cnt_reg <= wc_cnt_reg + 18'h00001;
        if (wc_cnt_reg == 18'(WRITE_CYCLE_CYCLES - 1))
        begin
          busy_reg <= 1'b0;
          wel_reg <= 1'b0;
        end
      end
      else if (cs_rise)
      begin
        if (state_reg == ST_DONE &&
            cmd_reg == spi_eeprom_pkg::SET_WRITE_LATCH_CMD)
        begin
          wel_reg <= 1'b1;
        end
        if (state_reg == ST_DONE &&
            cmd_reg == spi_eeprom_pkg::CLEAR_WRITE_LATCH_CMD)
        begin
          wel_reg <= 1'b0;
        end
        if (wr_ok || sr_ok)
        begin
          busy_reg <= 1'b1;
          start_reg <= 1'b1;
          wc_cnt_reg <= 18'h00000;
        end
        if (sr_ok)
        begin
          pen_reg <= sr_data_reg[spi_eeprom_pkg::SR_PROTECT_PIN_ENABLE_BIT];
          bp_hi_reg <= sr_data_reg[spi_eeprom_pkg::SR_BLOCK_PROTECT_HI_BIT];
          bp_lo_reg <= sr_data_reg[spi_eeprom_pkg::SR_BLOCK_PROTECT_LO_BIT];
        end
      end
    end
  end

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[spi_eeprom_pkg::SR_PROTECT_PIN_ENABLE_BIT] = pen_reg;
    status_byte[spi_eeprom_pkg::SR_BLOCK_PROTECT_HI_BIT] = bp_hi_reg;
    status_byte[spi_eeprom_pkg::SR_BLOCK_PROTECT_LO_BIT] = bp_lo_reg;
    status_byte[spi_eeprom_pkg::SR_WRITE_LATCH_BIT] = wel_reg;
    status_byte[spi_eeprom_pkg::SR_READY_BIT] = busy_reg;
  end

  // ---------------------------------------------------------------
  // serial output
  // ---------------------------------------------------------------
  assign out_state = (state_reg == ST_SR_RD) | (state_reg == ST_RDATA);
  assign src_byte = (state_reg == ST_SR_RD) ? status_byte : mem_rdata;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      so_reg <= 1'b0;
      out_sh_reg <= 8'h00;
      out_cnt_reg <= 3'h0;
    end
    else if (cs_n_s)
    begin
      out_cnt_reg <= 3'h0;
    end
    else if (sck_fall && out_state)
    begin
      out_cnt_reg <= out_cnt_reg + 3'h1;
      if (out_cnt_reg == 3'h0)
      begin
        so_reg <= src_byte[7];
        out_sh_reg <= {src_byte[6:0], 1'b0};
      end
      else
      begin
        so_reg <= out_sh_reg[7];
        out_sh_reg <= {out_sh_reg[6:0], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign link.so = so_reg;
  assign link.so_oe = ~cs_n_s & hold_n_s & out_state;
  assign mem_addr = addr_reg;
  assign mem_wdata = wdata_reg;
  assign mem_wr = mem_wr_reg;
  assign write_start = start_reg;
  assign write_busy = busy_reg;
  assign standby = cs_n_s & ~busy_reg;
  assign status = status_byte;

endmodule: spi_eeprom_dev

/* core/spi_eeprom_pkg.sv */
// shared constants for the serial eeprom device and host ends
package spi_eeprom_pkg;

  // ---------------------------------------------------------------
  // command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  localparam logic [7:0] READ_STATUS_CMD = 8'h05;
  localparam logic [7:0] WRITE_STATUS_CMD = 8'h01;
  localparam logic [7:0] READ_DATA_CMD = 8'h03;
  localparam logic [7:0] WRITE_DATA_CMD = 8'h02;

  // ---------------------------------------------------------------
  // status byte layout and reset values
  // ---------------------------------------------------------------
  localparam int SR_PROTECT_PIN_ENABLE_BIT = 7;
  localparam int SR_BLOCK_PROTECT_HI_BIT = 3;
  localparam int SR_BLOCK_PROTECT_LO_BIT = 2;
  localparam int SR_WRITE_LATCH_BIT = 1;
  localparam int SR_READY_BIT = 0;
  localparam logic PROTECT_PIN_ENABLE_RESET = 1'b0;
  localparam logic BLOCK_PROTECT_RESET = 1'b0;
  localparam logic WRITE_LATCH_RESET = 1'b0;
  // synchroniser reset: {hold_n, wp_n, si, sck, cs_n}
  localparam logic [4:0] LINK_IDLE = 5'h19;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int NS_PER_MS = 1000000;
  localparam int WRITE_CYCLE_MS = 5;
  localparam int POWERUP_MS = 1;
  localparam int WRITE_CYCLE_CYCLES =
    WRITE_CYCLE_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int POWERUP_CYCLES =
    (POWERUP_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCK_HALF_CYCLES = 4;

  // ---------------------------------------------------------------
  // host register map
  // ---------------------------------------------------------------
  localparam logic [7:0] HOST_CTRL_ADDR = 8'h00;
  localparam logic [7:0] HOST_DATA_ADDR = 8'h04;
  localparam logic [7:0] HOST_STAT_ADDR = 8'h08;
  localparam int CTRL_SELECT_BIT = 0;
  localparam int CTRL_PAUSE_BIT = 1;
  localparam int CTRL_WP_BIT = 2;
  localparam logic CTRL_WP_RESET = 1'b1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_POWERED_BIT = 1;
  localparam int STAT_SELECTED_BIT = 2;

endpackage: spi_eeprom_pkg

/* core/spi_link_if.sv */
// serial link between eeprom host and device
`timescale 1ns/1ps
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic wp_n;
  logic hold_n;

  modport dev (
    input cs_n,
    input sck,
    input si,
    input wp_n,
    input hold_n,
    output so,
    output so_oe
  );

  modport ctl (
    output cs_n,
    output sck,
    output si,
    output wp_n,
    output hold_n,
    input so,
    input so_oe
  );
endinterface: spi_link_if

/* core/spi_eeprom_host.sv */
// serial eeprom host end: register-driven byte transfers
`timescale 1ns/1ps
module spi_eeprom_host #(
  parameter int POWERUP_CYCLES = spi_eeprom_pkg::POWERUP_CYCLES
) (
  // clock and reset
  input logic core_clk,
  input logic rst,
  // serial link
  spi_link_if.ctl link,
  // register port
  input logic [7:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [31:0] reg_rdata
);

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LOW = 2'b01,
    H_HIGH = 2'b10
  } host_state_e;

  localparam logic [2:0] HALF_LAST =
    3'(spi_eeprom_pkg::SCK_HALF_CYCLES - 1);

  host_state_e state_reg;
  logic so_meta_reg;
  logic so_s_reg;
  logic select_req_reg;
  logic pause_req_reg;
  logic wp_reg;
  logic [15:0] pu_cnt_reg;
  logic pu_done_reg;
  logic cs_n_reg;
  logic hold_n_reg;
  logic sck_reg;
  logic si_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic [2:0] bit_reg;
  logic [2:0] div_reg;
  logic [31:0] rdata_reg;
  logic ctrl_wr;
  logic start;
  logic rise_due;

  // ---------------------------------------------------------------
  // input synchroniser and control register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      so_meta_reg <= 1'b0;
      so_s_reg <= 1'b0;
    end
    else
    begin
      so_meta_reg <= link.so;
      so_s_reg <= so_meta_reg;
    end
  end

  assign ctrl_wr = reg_wr & (reg_addr == spi_eeprom_pkg::HOST_CTRL_ADDR);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      select_req_reg <= 1'b0;
      pause_req_reg <= 1'b0;
      wp_reg <= spi_eeprom_pkg::CTRL_WP_RESET;
    end
    else if (ctrl_wr)
    begin
      select_req_reg <= reg_wdata[spi_eeprom_pkg::CTRL_SELECT_BIT];
      pause_req_reg <= reg_wdata[spi_eeprom_pkg::CTRL_PAUSE_BIT];
      wp_reg <= reg_wdata[spi_eeprom_pkg::CTRL_WP_BIT];
    end
  end

  // ---------------------------------------------------------------
  // power-up wait, select and pause pins
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pu_cnt_reg <= 16'h0000;
      pu_done_reg <= 1'b0;
    end
    else if (!pu_done_reg)
    begin
      pu_cnt_reg <= pu_cnt_reg + 16'h0001;
      if (pu_cnt_reg == 16'(POWERUP_CYCLES - 1))
      begin
        pu_done_reg <= 1'b1;
      end
    end
  end

  // no clock edge may coincide with a pause change
  assign rise_due = (state_reg == H_LOW) & (div_reg == HALF_LAST) &
    hold_n_reg;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cs_n_reg <= 1'b1;
      hold_n_reg <= 1'b1;
    end
    else
    begin
      if (pu_done_reg && state_reg == H_IDLE && hold_n_reg)
      begin
        cs_n_reg <= ~select_req_reg;
      end
      if (!sck_reg && !rise_due)
      begin
        hold_n_reg <= ~pause_req_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // byte shifter, mode zero
  // ---------------------------------------------------------------
  // software sends the latch-set frame before any write frame
  assign start = reg_wr & (reg_addr == spi_eeprom_pkg::HOST_DATA_ADDR) &
    (state_reg == H_IDLE) & ~cs_n_reg & hold_n_reg;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= H_IDLE;
      sck_reg <= 1'b0;
      si_reg <= 1'b0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      bit_reg <= 3'h0;
      div_reg <= 3'h0;
    end
    else
    begin
      unique case (state_reg)
        H_IDLE:
        begin
          if (start)
          begin
            tx_reg <= reg_wdata[7:0];
            si_reg <= reg_wdata[7];
            bit_reg <= 3'h0;
            div_reg <= 3'h0;
            state_reg <= H_LOW;
          end
        end
        H_LOW:
        begin
          if (hold_n_reg)
          begin
            div_reg <= div_reg + 3'h1;
            if (div_reg == HALF_LAST)
            begin
              div_reg <= 3'h0;
              sck_reg <= 1'b1;
              state_reg <= H_HIGH;
            end
          end
        end
        H_HIGH:
        begin
          div_reg <= div_reg + 3'h1;
          if (div_reg == HALF_LAST)
          begin
            div_reg <= 3'h0;
            sck_reg <= 1'b0;
            rx_reg <= {rx_reg[6:0], so_s_reg};
            si_reg <= tx_reg[6];
            tx_reg <= {tx_reg[6:0], 1'b0};
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'h7)
            begin
              state_reg <= H_IDLE;
            end
            else
            begin
              state_reg <= H_LOW;
            end
          end
        end
        default:
        begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_reg <= 32'h00000000;
    end
    else
    begin
      rdata_reg <= 32'h00000000;
      if (reg_rd)
      begin
        unique case (reg_addr)
          spi_eeprom_pkg::HOST_CTRL_ADDR:
          begin
            rdata_reg[spi_eeprom_pkg::CTRL_SELECT_BIT] <= select_req_reg;
            rdata_reg[spi_eeprom_pkg::CTRL_PAUSE_BIT] <= pause_req_reg;
            rdata_reg[spi_eeprom_pkg::CTRL_WP_BIT] <= wp_reg;
          end
          spi_eeprom_pkg::HOST_DATA_ADDR:
          begin
            rdata_reg[7:0] <= rx_reg;
          end
          spi_eeprom_pkg::HOST_STAT_ADDR:
          begin
            rdata_reg[spi_eeprom_pkg::STAT_BUSY_BIT] <= state_reg != H_IDLE;
            rdata_reg[spi_eeprom_pkg::STAT_POWERED_BIT] <= pu_done_reg;
            rdata_reg[spi_eeprom_pkg::STAT_SELECTED_BIT] <= ~cs_n_reg;
          end
          default:
          begin
            rdata_reg <= 32'h00000000;
          end
        endcase
      end
    end
  end

  assign link.cs_n = cs_n_reg;
  assign link.sck = sck_reg;
  assign link.si = si_reg;
  assign link.wp_n = wp_reg;
  assign link.hold_n = hold_n_reg;
  assign reg_rdata = rdata_reg;

endmodule: spi_eeprom_host

/* testbench/spi_eeprom_assertions.sv */
// link and write cycle checker for the serial eeprom
`timescale 1ns/1ps
module spi_eeprom_assertions #(
  parameter int POWERUP_CYCLES = 10,
  parameter int WRITE_CYCLE_CYCLES = 40
) (
  // clock and reset
  input logic core_clk,
  input logic rst,
  // link
  input logic cs_n,
  input logic sck,
  input logic si,
  input logic so,
  input logic so_oe,
  input logic wp_n,
  input logic hold_n,
  // device state
  input logic write_busy
);
  int up_cnt;
  int busy_cnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      up_cnt <= 0;
    else if (up_cnt < POWERUP_CYCLES)
      up_cnt <= up_cnt + 1;
  // cycles spent in the write cycle so far
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      busy_cnt <= 0;
    else
      busy_cnt <= write_busy ? busy_cnt + 1 : 0;
  a_si_held_high: assert property (sck && $past(sck) |-> $stable(si))
    else $error("data in moved with clock high");
  a_so_low_change: assert property (so_oe && $past(so_oe) && $changed(so)
    |-> !$past(sck) && !$past(sck, 2))
    else $error("data out moved outside clock low");
  a_so_off_idle: assert property (cs_n [*4] |-> !so_oe)
    else $error("data out driven while deselected");
  a_cs_fall_low: assert property ($fell(cs_n) |-> !sck)
    else $error("select fell with clock high");
  a_pause_sck_low: assert property ($changed(hold_n)
    |-> !sck && !$past(sck))
    else $error("pause moved with clock high");
  a_pause_so_off: assert property (!hold_n [*4] |-> !so_oe)
    else $error("data out driven while paused");
  a_clock_idle: assert property (cs_n |-> !sck)
    else $error("clock not idle low");
  a_cycle_len: assert property ($fell(write_busy)
    |-> busy_cnt >= WRITE_CYCLE_CYCLES - 1
    && busy_cnt <= WRITE_CYCLE_CYCLES + 1)
    else $error("write cycle length wrong");
  a_cycle_start: assert property ($rose(write_busy) |-> cs_n)
    else $error("write cycle began while selected");
  a_power_wait: assert property ($fell(cs_n)
    |-> up_cnt >= POWERUP_CYCLES)
    else $error("select before power-up wait");
  cover property ($rose(write_busy));
  cover property ($fell(hold_n));
  cover property (so_oe && !cs_n);
endmodule: spi_eeprom_assertions

/* testbench/spi_eeprom_command_interface_tb.sv */
// bench for both eeprom ends joined by the link
`timescale 1ns/1ps
module spi_eeprom_command_interface_tb;
  localparam int WC = 1500;
  localparam int PU = 10;
  localparam logic [7:0] CT = spi_eeprom_pkg::HOST_CTRL_ADDR;
  localparam logic [7:0] DA = spi_eeprom_pkg::HOST_DATA_ADDR;
  localparam logic [7:0] ST = spi_eeprom_pkg::HOST_STAT_ADDR;
  localparam logic [7:0] RS = spi_eeprom_pkg::READ_STATUS_CMD;
  localparam logic [7:0] SL = spi_eeprom_pkg::SET_WRITE_LATCH_CMD;
  localparam logic [7:0] CL = spi_eeprom_pkg::CLEAR_WRITE_LATCH_CMD;
  localparam logic [7:0] WS = spi_eeprom_pkg::WRITE_STATUS_CMD;
  logic core_clk, rst, reg_wr, reg_rd, mem_wr, write_start;
  logic write_busy, standby;
  logic [7:0] reg_addr, mem_rdata, mem_wdata, status, rx, wr_data;
  logic [15:0] mem_addr, wr_addr;
  logic [31:0] reg_wdata, reg_rdata, q;
  logic [2:0] ctl;
  int err_total, cmp_count, n_start;
  spi_link_if u_spi_link_if();
  spi_eeprom_dev #(.WRITE_CYCLE_CYCLES(WC)) u_spi_eeprom_dev (
    .core_clk(core_clk), .rst(rst), .link(u_spi_link_if),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata),
    .mem_wr(mem_wr), .write_start(write_start), .write_busy(write_busy),
    .standby(standby), .status(status));
  spi_eeprom_host #(.POWERUP_CYCLES(PU)) u_spi_eeprom_host (
    .core_clk(core_clk), .rst(rst), .link(u_spi_link_if),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  spi_eeprom_assertions #(.POWERUP_CYCLES(PU), .WRITE_CYCLE_CYCLES(WC))
    u_spi_eeprom_assertions (
    .core_clk(core_clk), .rst(rst), .cs_n(u_spi_link_if.cs_n),
    .sck(u_spi_link_if.sck), .si(u_spi_link_if.si),
    .so(u_spi_link_if.so), .so_oe(u_spi_link_if.so_oe),
    .wp_n(u_spi_link_if.wp_n), .hold_n(u_spi_link_if.hold_n),
    .write_busy(write_busy));
  assign mem_rdata = mem_addr[7:0] ^ 8'h5a;
  always @(posedge core_clk)
    if (mem_wr === 1'b1)
    begin
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
    end
  always @(posedge core_clk)
    if (write_start === 1'b1)
      n_start <= n_start + 1;
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ---------------------------------------------------------------
  // register access and compares
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask: report_and_stop
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask: chk8
  task automatic chk1(input logic g, input logic e);
    chk8({7'h0, g}, {7'h0, e});
  endtask: chk1
  task automatic acc(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
    @(posedge core_clk);
  endtask: acc
  task automatic give_up();
    err_total++;
    $display("[ERR] %0t wait ran out", $time);
    report_and_stop();
  endtask: give_up
  task automatic wait_stat(input int b, input logic v);
    for (int i = 0; i < 3000; i++)
    begin
      acc(1'b0, ST, 32'h0);
      if (q[b] === v)
        return;
    end
    give_up();
  endtask: wait_stat
  task automatic wait_idle();
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge core_clk);
      if (write_busy === 1'b0)
        return;
    end
    give_up();
  endtask: wait_idle
  task automatic sel(input logic v);
    ctl[0] = v;
    acc(1'b1, CT, {29'h0, ctl});
    wait_stat(2, v);
    repeat (4) @(posedge core_clk);
  endtask: sel
  task automatic xfer(input logic [7:0] tx);
    acc(1'b1, DA, {24'h0, tx});
    wait_stat(0, 1'b0);
    acc(1'b0, DA, 32'h0);
    rx = q[7:0];
  endtask: xfer
  task automatic frame(input int n, input logic [31:0] bs);
    sel(1'b1);
    for (int i = 0; i < n; i++)
      xfer(bs[31-8*i -: 8]);
    sel(1'b0);
  endtask: frame
  task automatic wsr(input logic [7:0] v);
    frame(1, {SL, 24'h0});
    frame(2, {WS, v, 16'h0});
    wait_idle();
    frame(2, {RS, 24'h0});
  endtask: wsr
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_latch();
    frame(2, {RS, 24'h0});
    chk8(rx, 8'h00);
    chk1(standby, 1'b1);
    frame(1, {SL, 24'h0});
    frame(2, {RS, 24'h0});
    chk8(rx, 8'h02);
    frame(1, {CL, 24'h0});
    frame(2, {RS, 24'h0});
    chk8(rx, 8'h00);
  endtask: t_latch
  task automatic t_bad_op();
    frame(1, {SL, 24'h0});
    sel(1'b1);
    xfer(8'hff);
    chk1(u_spi_link_if.so_oe, 1'b0);
    xfer(RS);
    chk1(u_spi_link_if.so_oe, 1'b0);
    sel(1'b0);
    frame(2, {RS, 24'h0});
    chk8(rx, 8'h02);
    frame(1, {CL, 24'h0});
  endtask: t_bad_op
  task automatic t_protect();
    wsr(8'h8c);
    chk8(rx & 8'hfc, 8'h8c);
    ctl[2] = 1'b0;
    acc(1'b1, CT, {29'h0, ctl});
    wsr(8'h00);
    chk8(rx & 8'hfc, 8'h8c);
    ctl[2] = 1'b1;
    acc(1'b1, CT, {29'h0, ctl});
    wsr(8'h00);
    chk8(rx & 8'hfc, 8'h00);
    wait_idle();
  endtask: t_protect
  task automatic t_mem_wr();
    frame(1, {SL, 24'h0});
    frame(4, {spi_eeprom_pkg::WRITE_DATA_CMD, 16'h0010, 8'ha5});
    chk8(wr_data, 8'ha5);
    chk8(wr_addr[7:0], 8'h10);
    chk1(standby, 1'b0);
    chk8(status, 8'h03);
    frame(2, {RS, 24'h0});
    chk8(rx, 8'h03);
    frame(2, {WS, 8'h8c, 16'h0});
    wait_idle();
    frame(2, {RS, 24'h0});
    chk8(rx, 8'h00);
    chk8(8'(n_start), 8'h03);
  endtask: t_mem_wr
  task automatic t_mem_rd();
    sel(1'b1);
    xfer(spi_eeprom_pkg::READ_DATA_CMD);
    xfer(8'h00);
    xfer(8'h20);
    xfer(8'h00);
    chk8(rx, 8'h7a);
    xfer(8'h00);
    chk8(rx, 8'h7b);
    sel(1'b0);
  endtask: t_mem_rd
  task automatic t_pause();
    frame(1, {SL, 24'h0});
    sel(1'b1);
    xfer(RS);
    chk1(u_spi_link_if.so_oe, 1'b1);
    ctl[1] = 1'b1;
    acc(1'b1, CT, {29'h0, ctl});
    repeat (8) @(posedge core_clk);
    chk1(u_spi_link_if.so_oe, 1'b0);
    ctl[1] = 1'b0;
    acc(1'b1, CT, {29'h0, ctl});
    xfer(8'h00);
    chk8(rx, 8'h02);
    sel(1'b0);
  endtask: t_pause
  initial
  begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ctl = 3'h4;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    acc(1'b0, 8'hfc, 32'h0);
    chk8(q[7:0], 8'h00);
    t_latch();
    t_bad_op();
    t_protect();
    t_mem_wr();
    t_mem_rd();
    t_pause();
    report_and_stop();
  end
endmodule: spi_eeprom_command_interface_tb
